// >>> design/acst_control_two.sv
// Second control register of the asynchronous serial port, with break and idle queueing
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module acst_control_two
  import acst_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  input wire logic [ACST_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic xmit_buf_load,
  input wire logic xmit_data_write,
  input wire logic xmit_data_active,
  input wire logic xmit_done,
  input wire logic rcv_buf_full,
  input wire logic line_quiet,
  input wire logic bit_tick,
  input wire logic rcv_idle_seen,
  input wire logic rcv_char_done,
  input wire logic rcv_msb,
  output logic irq,
  output logic xmit_buf_empty,
  output logic xmit_enable,
  output logic xmit_pin_drive,
  output logic xmit_pin_oe,
  output logic rcv_enable,
  output logic rcv_pin_own,
  output logic rcv_standby,
  output logic baud_run,
  output logic line_low,
  output logic line_mark,
  output logic seq_busy,
  output logic nine_bit_sel
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [7:0] ctrl2_r;
  logic [LN_W-1:0] line_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic buf_empty_r;
  logic baud_run_r;
  logic brk_pend_r;
  logic idle_pend_r;
  acst_seq_t seq_r;
  logic [3:0] bit_cnt_r;

  logic wr_ctrl2;
  logic wr_line;
  logic xmit_rise;
  logic brk_rise;
  logic wake_hit;
  logic internal_loop_sel;
  logic rcv_source_sel;
  logic single_wire_dir;
  logic wake_sel;
  logic xmit_busy;
  logic [3:0] char_len;
  logic char_end;
  logic [7:0] status;

  assign wr_ctrl2 = enable && reg_wr && reg_addr == ADDR_CTRL2;
  assign wr_line = enable && reg_wr && reg_addr == ADDR_LINE;
  assign xmit_rise = wr_ctrl2 && reg_wdata[C2_XMIT_ON] && !ctrl2_r[C2_XMIT_ON];
  assign brk_rise = wr_ctrl2 && reg_wdata[C2_BRK] && !ctrl2_r[C2_BRK];

  assign internal_loop_sel = line_r[LN_LOOP];
  assign rcv_source_sel = line_r[LN_SRC];
  assign single_wire_dir = line_r[LN_DIR];
  assign wake_sel = line_r[LN_WAKE];
  assign nine_bit_sel = line_r[LN_NINE];

  // Idle line ends standby, or with the wake bit set a marked top data bit instead
  assign wake_hit = wake_sel ? (rcv_char_done && rcv_msb) : rcv_idle_seen;

  // No lockout: writes land whatever the transmitter or receiver is doing
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl2_r <= CTRL2_RESET;
    end else if (wr_ctrl2) begin
      ctrl2_r <= reg_wdata;
    end else if (enable && ctrl2_r[C2_STANDBY] && wake_hit) begin
      ctrl2_r[C2_STANDBY] <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      line_r <= LINE_RESET[LN_W-1:0];
    end else if (wr_line) begin
      line_r <= reg_wdata[LN_W-1:0];
    end
  end

  assign status = {buf_empty_r, xmit_done, rcv_buf_full, line_quiet, xmit_busy,
                   seq_r == ACST_SEQ_BREAK, seq_r == ACST_SEQ_PREAMBLE, baud_run_r};

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (enable) begin
      if (reg_rd) begin
        case (reg_addr)
          ADDR_CTRL2: rdata_r <= ctrl2_r;
          ADDR_LINE: rdata_r <= {{(8-LN_W){1'b0}}, line_r};
          ADDR_STAT: rdata_r <= status;
          default: rdata_r <= 8'h00;
        endcase
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt request and buffer-empty flag

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else if (enable) begin
      irq_r <= (ctrl2_r[C2_BUF_IRQ] && buf_empty_r) ||
               (ctrl2_r[C2_DONE_IRQ] && xmit_done) ||
               (ctrl2_r[C2_FULL_IRQ] && rcv_buf_full) ||
               (ctrl2_r[C2_QUIET_IRQ] && line_quiet);
    end
  end

  assign irq = irq_r;

  // A load in the same cycle as a data write wins: the buffer really emptied
  always_ff @(posedge clock) begin
    if (reset) begin
      buf_empty_r <= 1'b1;
    end else if (enable) begin
      if (xmit_buf_load) begin
        buf_empty_r <= 1'b1;
      end else if (xmit_data_write) begin
        buf_empty_r <= 1'b0;
      end
    end
  end

  assign xmit_buf_empty = buf_empty_r;

  // Sticky: later clearing of both enables does not stop the generator
  always_ff @(posedge clock) begin
    if (reset) begin
      baud_run_r <= 1'b0;
    end else if (wr_ctrl2 && (reg_wdata[C2_XMIT_ON] || reg_wdata[C2_RCV_ON])) begin
      baud_run_r <= 1'b1;
    end
  end

  assign baud_run = baud_run_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Queued break and idle characters

  assign char_len = nine_bit_sel ? CHAR_BITS_9 : CHAR_BITS_8;
  assign char_end = bit_tick && bit_cnt_r >= char_len - CNT_ONE;

  // Set wins over the clear taken when the sequencer starts
  always_ff @(posedge clock) begin
    if (reset) begin
      brk_pend_r <= 1'b0;
    end else if (enable) begin
      if (brk_rise && ctrl2_r[C2_XMIT_ON]) begin
        brk_pend_r <= 1'b1;
      end else if (seq_r == ACST_SEQ_QUIET && !xmit_data_active) begin
        brk_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      idle_pend_r <= 1'b0;
    end else if (enable) begin
      if (xmit_rise) begin
        idle_pend_r <= 1'b1;
      end else if (seq_r == ACST_SEQ_QUIET && !xmit_data_active && !brk_pend_r) begin
        idle_pend_r <= 1'b0;
      end
    end
  end

  // Queued characters wait for the data shifter; break goes before idle
  always_ff @(posedge clock) begin
    if (reset) begin
      seq_r <= ACST_SEQ_QUIET;
      bit_cnt_r <= 4'h0;
    end else if (enable) begin
      case (seq_r)
        ACST_SEQ_QUIET: begin
          bit_cnt_r <= 4'h0;
          if (!xmit_data_active && brk_pend_r) begin
            seq_r <= ACST_SEQ_BREAK;
          end else if (!xmit_data_active && idle_pend_r) begin
            seq_r <= ACST_SEQ_PREAMBLE;
          end
        end
        ACST_SEQ_BREAK: begin
          if (char_end) begin
            bit_cnt_r <= 4'h0;
            // Bit still high, with the transmitter on, at the end of a break starts another one
            if (!(ctrl2_r[C2_BRK] && ctrl2_r[C2_XMIT_ON])) begin
              seq_r <= ACST_SEQ_QUIET;
            end
          end else if (bit_tick) begin
            bit_cnt_r <= bit_cnt_r + CNT_ONE;
          end
        end
        ACST_SEQ_PREAMBLE: begin
          if (char_end) begin
            bit_cnt_r <= 4'h0;
            seq_r <= ACST_SEQ_QUIET;
          end else if (bit_tick) begin
            bit_cnt_r <= bit_cnt_r + CNT_ONE;
          end
        end
        default: begin
          seq_r <= ACST_SEQ_QUIET;
          bit_cnt_r <= 4'h0;
        end
      endcase
    end
  end

  assign line_low = seq_r == ACST_SEQ_BREAK;
  assign line_mark = seq_r == ACST_SEQ_PREAMBLE;
  assign seq_busy = seq_r != ACST_SEQ_QUIET || brk_pend_r || idle_pend_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin ownership

  assign xmit_busy = xmit_data_active || seq_busy;
  assign xmit_enable = ctrl2_r[C2_XMIT_ON];

  // Off bit only takes the pin back once queued traffic has drained
  assign xmit_pin_drive = (ctrl2_r[C2_XMIT_ON] || xmit_busy) &&
                          !(internal_loop_sel && !rcv_source_sel);
  assign xmit_pin_oe = xmit_pin_drive &&
                       (!(internal_loop_sel && rcv_source_sel) || single_wire_dir);

  assign rcv_enable = ctrl2_r[C2_RCV_ON];
  // In loop modes the receive pin is never used
  assign rcv_pin_own = ctrl2_r[C2_RCV_ON] && !internal_loop_sel;
  assign rcv_standby = ctrl2_r[C2_STANDBY];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_read_ctrl_two: assert property (
    enable && reg_rd && reg_addr == ADDR_CTRL2 && !reg_wr |=> reg_rdata == $past(ctrl2_r)
  ) else $error("control-two read data wrong");

  a_irq_buf_empty: assert property (
    enable && ctrl2_r[C2_BUF_IRQ] && buf_empty_r |=> irq
  ) else $error("buffer-empty interrupt missing");

  a_irq_xmit_done: assert property (
    enable && ctrl2_r[C2_DONE_IRQ] && xmit_done |=> irq
  ) else $error("transmission-done interrupt missing");

  a_irq_rcv_full: assert property (
    enable && ctrl2_r[C2_FULL_IRQ] && rcv_buf_full |=> irq
  ) else $error("receive-full interrupt missing");

  a_irq_line_quiet: assert property (
    enable && ctrl2_r[C2_QUIET_IRQ] && line_quiet |=> irq
  ) else $error("idle-line interrupt missing");

  a_irq_all_masked: assert property (
    enable && !(ctrl2_r[C2_BUF_IRQ] && buf_empty_r) && !(ctrl2_r[C2_DONE_IRQ] && xmit_done) &&
    !(ctrl2_r[C2_FULL_IRQ] && rcv_buf_full) && !(ctrl2_r[C2_QUIET_IRQ] && line_quiet) |=> !irq
  ) else $error("interrupt without enabled source");

  a_pin_on_drive: assert property (
    ctrl2_r[C2_XMIT_ON] && !internal_loop_sel |-> xmit_pin_drive && xmit_pin_oe
  ) else $error("transmit pin not driven");

  a_loop_release: assert property (
    internal_loop_sel && !rcv_source_sel |-> !xmit_pin_drive && !xmit_pin_oe
  ) else $error("transmit pin held in internal loop");

  a_single_wire_dir: assert property (
    xmit_pin_drive && internal_loop_sel && rcv_source_sel |-> xmit_pin_oe == single_wire_dir
  ) else $error("single-wire direction ignored");

  a_idle_queued: assert property (
    xmit_rise |=> idle_pend_r || seq_r == ACST_SEQ_PREAMBLE
  ) else $error("idle character not queued");

  a_pin_held_busy: assert property (
    !ctrl2_r[C2_XMIT_ON] && xmit_busy && !internal_loop_sel |-> xmit_pin_drive
  ) else $error("pin released before traffic ended");

  a_rcv_pin_off: assert property (
    !ctrl2_r[C2_RCV_ON] |-> !rcv_pin_own
  ) else $error("receive pin owned while receiver off");

  a_wake_clears: assert property (
    enable && ctrl2_r[C2_STANDBY] && !wr_ctrl2 && wake_hit |=> !rcv_standby
  ) else $error("standby not cleared on wakeup");

  a_break_start: assert property (
    enable && brk_pend_r && seq_r == ACST_SEQ_QUIET && !xmit_data_active
    |=> seq_r == ACST_SEQ_BREAK ##0 line_low
  ) else $error("queued break not started");

  a_break_repeat: assert property (
    enable && seq_r == ACST_SEQ_BREAK && char_end && ctrl2_r[C2_BRK] && ctrl2_r[C2_XMIT_ON]
    |=> line_low && bit_cnt_r == 4'h0
  ) else $error("held break bit did not repeat break");

  a_char_length: assert property (
    seq_r != ACST_SEQ_QUIET |-> bit_cnt_r < char_len
  ) else $error("character ran past its length");

  a_buf_empty_set: assert property (
    enable && xmit_buf_load |=> xmit_buf_empty
  ) else $error("buffer-empty not set on load");

  a_baud_held_off: assert property (
    !baud_run_r |-> !ctrl2_r[C2_XMIT_ON] && !ctrl2_r[C2_RCV_ON]
  ) else $error("baud generator idle while enabled");

  c_break_sent: cover property (seq_r == ACST_SEQ_BREAK ##1 seq_r == ACST_SEQ_QUIET);
  c_idle_sent: cover property (seq_r == ACST_SEQ_PREAMBLE ##1 seq_r == ACST_SEQ_QUIET);
  c_wakeup: cover property (rcv_standby ##1 !rcv_standby);
  c_single_wire_rx: cover property (xmit_pin_drive && !xmit_pin_oe);

endmodule

`default_nettype wire

// >>> design/acst_pkg.sv
// Constants and types for the serial control-two block
package acst_pkg;

  localparam int ACST_ADDR_W = 2;
  localparam logic [1:0] ADDR_CTRL2 = 2'h0;
  localparam logic [1:0] ADDR_LINE = 2'h1;
  localparam logic [1:0] ADDR_STAT = 2'h2;

  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] LINE_RESET = 8'h00;

  // Control-two field positions
  localparam int C2_BUF_IRQ = 7;
  localparam int C2_DONE_IRQ = 6;
  localparam int C2_FULL_IRQ = 5;
  localparam int C2_QUIET_IRQ = 4;
  localparam int C2_XMIT_ON = 3;
  localparam int C2_RCV_ON = 2;
  localparam int C2_STANDBY = 1;
  localparam int C2_BRK = 0;

  // Line configuration field positions
  localparam int LN_LOOP = 0;
  localparam int LN_SRC = 1;
  localparam int LN_DIR = 2;
  localparam int LN_WAKE = 3;
  localparam int LN_NINE = 4;
  localparam int LN_W = 5;

  // Status field positions
  localparam int ST_BUF_EMPTY = 7;
  localparam int ST_DONE = 6;
  localparam int ST_FULL = 5;
  localparam int ST_QUIET = 4;
  localparam int ST_BUSY = 3;
  localparam int ST_BRK = 2;
  localparam int ST_PRE = 1;
  localparam int ST_BAUD = 0;

  // Character length in bit times, start and stop included
  localparam logic [3:0] CHAR_BITS_8 = 4'ha;
  localparam logic [3:0] CHAR_BITS_9 = 4'hb;
  localparam logic [3:0] CNT_ONE = 4'h1;

  typedef enum logic [1:0] {
    ACST_SEQ_QUIET,
    ACST_SEQ_BREAK,
    ACST_SEQ_PREAMBLE
  } acst_seq_t;

endpackage

// >>> tb/acst_far_model.sv
// Far-side model: baud tick source and transmit data shifter
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module acst_far_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic baud_run,
  input wire logic seq_busy,
  input wire logic send,
  output logic bit_tick,
  output logic xmit_buf_load,
  output logic xmit_data_active
);
  logic [1:0] div_r;
  logic [3:0] bits_r;
  logic pend_r;

  // Short bit time keeps break and idle runs cheap
  always_ff @(posedge clock) begin
    if (reset || !baud_run) begin
      div_r <= 2'h0;
      bit_tick <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      bit_tick <= (div_r == 2'h3);
    end
  end

  // Data waits while a break or idle owns the line
  always_ff @(posedge clock) begin
    xmit_buf_load <= !reset && !send && pend_r && !seq_busy && !xmit_data_active;
    if (reset) begin
      pend_r <= 1'b0;
      xmit_data_active <= 1'b0;
      bits_r <= 4'h0;
    end else if (send) begin
      pend_r <= 1'b1;
    end else if (pend_r && !seq_busy && !xmit_data_active) begin
      pend_r <= 1'b0;
      xmit_data_active <= 1'b1;
      bits_r <= 4'ha;
    end else if (xmit_data_active && bit_tick) begin
      bits_r <= bits_r - 4'h1;
      xmit_data_active <= (bits_r != 4'h1);
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_acst_control_two.sv
// Register-level testbench for the serial control-two block
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: %h expected %h", $time, g, e); end end

////////////////////////////////////////////////////////////////////////////////
module tb_acst_control_two
  import acst_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic enable = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, send = 1'b0, xmit_data_write = 1'b0;
  logic xmit_done = 1'b0, rcv_buf_full = 1'b0, line_quiet = 1'b0, rcv_msb = 1'b0;
  logic rcv_idle_seen = 1'b0, rcv_char_done = 1'b0;
  logic [7:0] reg_rdata, d;
  logic irq, xmit_buf_empty, xmit_enable, xmit_pin_drive, xmit_pin_oe, rcv_enable;
  logic rcv_pin_own, rcv_standby, baud_run, line_low, line_mark, seq_busy;
  logic nine_bit_sel, bit_tick, xmit_buf_load, xmit_data_active;
  logic [7:0] cfg [4] = '{8'h01, 8'h03, 8'h07, 8'h00};
  logic [2:0] exp_pins [4] = '{3'b000, 3'b100, 3'b110, 3'b111};
  int miscompares = 0, checked = 0, low_ticks = 0, mark_ticks = 0, base;

  always #25 clock = ~clock;

  acst_control_two acst_control_two_i (.clock(clock), .reset(reset), .enable(enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .xmit_buf_load(xmit_buf_load), .xmit_data_write(xmit_data_write),
    .xmit_data_active(xmit_data_active), .xmit_done(xmit_done), .rcv_buf_full(rcv_buf_full),
    .line_quiet(line_quiet), .bit_tick(bit_tick), .rcv_idle_seen(rcv_idle_seen),
    .rcv_char_done(rcv_char_done), .rcv_msb(rcv_msb), .irq(irq),
    .xmit_buf_empty(xmit_buf_empty), .xmit_enable(xmit_enable),
    .xmit_pin_drive(xmit_pin_drive), .xmit_pin_oe(xmit_pin_oe), .rcv_enable(rcv_enable),
    .rcv_pin_own(rcv_pin_own), .rcv_standby(rcv_standby), .baud_run(baud_run),
    .line_low(line_low), .line_mark(line_mark), .seq_busy(seq_busy),
    .nine_bit_sel(nine_bit_sel));

  acst_far_model acst_far_model_i (.clock(clock), .reset(reset), .baud_run(baud_run),
    .seq_busy(seq_busy), .send(send), .bit_tick(bit_tick), .xmit_buf_load(xmit_buf_load),
    .xmit_data_active(xmit_data_active));

  // Bit times seen on the line, split by level
  always @(posedge clock) begin
    if (bit_tick && line_low) low_ticks++;
    if (bit_tick && line_mark) mark_ticks++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks made %0d, wrong %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask

  task automatic pulse(input int w);
    @(posedge clock);
    case (w)
      0: xmit_data_write <= 1'b1;
      1: send <= 1'b1;
      2: rcv_idle_seen <= 1'b1;
      default: rcv_char_done <= 1'b1;
    endcase
    @(posedge clock);
    {xmit_data_write, send, rcv_idle_seen, rcv_char_done} <= 4'h0;
  endtask

  // Bounded wait: 0 seq_busy, 1 line_mark, 2 xmit_data_active
  task automatic wait_sig(input int w, input logic v);
    int i;
    logic s;
    for (i = 0; i < 600; i++) begin
      @(negedge clock);
      s = (w == 0) ? seq_busy : (w == 1) ? line_mark : xmit_data_active;
      if (s === v) break;
    end
    if (i == 600) begin
      miscompares++;
      $display("wrong value at %0t: wait ran out", $time);
      final_report();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    rd(ADDR_CTRL2, d); `CHK(d, CTRL2_RESET)
    rd(ADDR_LINE, d); `CHK(d, LINE_RESET)
    rd(ADDR_STAT, d); `CHK(d, 8'h80)
    wr(2'h3, 8'hff); rd(2'h3, d); `CHK(d, 8'h00)
    rd(ADDR_CTRL2, d); `CHK(d, CTRL2_RESET)
    `CHK({baud_run, irq}, 2'b00)
    $display("end of test reset");

    wr(ADDR_CTRL2, 8'h80); cyc(2); `CHK(irq, 1'b1)
    wr(ADDR_CTRL2, 8'h70); cyc(2); `CHK(irq, 1'b0)
    rd(ADDR_CTRL2, d); `CHK(d, 8'h70)
    pulse(0); cyc(1); `CHK(xmit_buf_empty, 1'b0)
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      {xmit_done, rcv_buf_full, line_quiet} <= 3'h4 >> i;
      wr(ADDR_CTRL2, 8'hf0 ^ (8'h40 >> i)); cyc(2); `CHK(irq, 1'b0)
      wr(ADDR_CTRL2, 8'h40 >> i); cyc(2); `CHK(irq, 1'b1)
    end
    @(posedge clock);
    {xmit_done, rcv_buf_full, line_quiet} <= 3'h0;
    $display("end of test interrupts");

    wr(ADDR_CTRL2, 8'h0c); cyc(2);
    `CHK(baud_run, 1'b1)
    `CHK({xmit_enable, rcv_enable, xmit_pin_drive, xmit_pin_oe, rcv_pin_own}, 5'h1f)
    wait_sig(1, 1'b1); base = mark_ticks; wait_sig(0, 1'b0);
    `CHK(mark_ticks - base, int'(CHAR_BITS_8))
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_LINE, cfg[i]); cyc(1);
      `CHK({xmit_pin_drive, xmit_pin_oe, rcv_pin_own}, exp_pins[i])
    end
    $display("end of test pins");

    wr(ADDR_CTRL2, 8'h04); cyc(1); `CHK(xmit_pin_drive, 1'b0)
    wr(ADDR_CTRL2, 8'h0c); wait_sig(1, 1'b1); wr(ADDR_CTRL2, 8'h04); cyc(1);
    `CHK({xmit_pin_drive, line_mark}, 2'b11)
    wait_sig(0, 1'b0); cyc(1); `CHK(xmit_pin_drive, 1'b0)
    wr(ADDR_CTRL2, 8'h0c); wait_sig(1, 1'b1); wait_sig(0, 1'b0);
    pulse(1); wait_sig(2, 1'b1); cyc(1); `CHK(xmit_buf_empty, 1'b1)
    wr(ADDR_CTRL2, 8'h04); wr(ADDR_CTRL2, 8'h0c); cyc(1);
    `CHK({seq_busy, line_mark, xmit_pin_drive}, 3'b101)
    wait_sig(1, 1'b1); `CHK(xmit_data_active, 1'b0)
    base = mark_ticks; wait_sig(0, 1'b0);
    `CHK(mark_ticks - base, int'(CHAR_BITS_8))
    $display("end of test idle");

    wr(ADDR_LINE, 8'h10); cyc(1); `CHK(nine_bit_sel, 1'b1)
    base = low_ticks; wr(ADDR_CTRL2, 8'h0d); wr(ADDR_CTRL2, 8'h0c); wait_sig(0, 1'b0);
    `CHK(low_ticks - base, int'(CHAR_BITS_9))
    wr(ADDR_LINE, 8'h00);
    // Clear lands inside the second break, so exactly two go out
    base = low_ticks; wr(ADDR_CTRL2, 8'h0d); cyc(60); wr(ADDR_CTRL2, 8'h0c); wait_sig(0, 1'b0);
    `CHK(low_ticks - base, 2 * int'(CHAR_BITS_8))
    $display("end of test break");

    wr(ADDR_CTRL2, 8'h06); cyc(1); `CHK(rcv_standby, 1'b1)
    @(posedge clock); rcv_msb <= 1'b1; pulse(3); cyc(2); `CHK(rcv_standby, 1'b1)
    pulse(2); cyc(2); `CHK(rcv_standby, 1'b0)
    wr(ADDR_LINE, 8'h08); wr(ADDR_CTRL2, 8'h06);
    pulse(2); cyc(2); `CHK(rcv_standby, 1'b1)
    @(posedge clock); rcv_msb <= 1'b0; pulse(3); cyc(2); `CHK(rcv_standby, 1'b1)
    @(posedge clock); rcv_msb <= 1'b1; pulse(3); cyc(2); `CHK(rcv_standby, 1'b0)
    wr(ADDR_CTRL2, 8'h00); cyc(1); `CHK({rcv_enable, rcv_pin_own}, 2'b00)
    // Clock enable low: the write must not land
    @(posedge clock); enable <= 1'b0;
    wr(ADDR_CTRL2, 8'h0c);
    @(posedge clock); enable <= 1'b1;
    rd(ADDR_CTRL2, d); `CHK(d, 8'h00)
    `CHK(xmit_pin_drive, 1'b0)
    $display("end of test standby");
    final_report();
  end
endmodule
`default_nettype wire
